// ===== src/mad_pkg.sv
package mad_pkg;

  // ************************************************
  // Register map (byte addresses, one word each)
  // ************************************************
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_RES_LO = 8'h04;
  localparam logic [7:0] REG_RES_HI = 8'h08;

  // ************************************************
  // Datapath widths
  // ************************************************
  localparam int ACC_W   = 48;
  localparam int A_W     = 19;
  localparam int B_W     = 18;
  localparam int DUAL_W  = 24;
  localparam int QUAD_W  = 12;
  localparam int DA_W    = 11;
  localparam int DB_W    = 10;
  localparam int D8_W    = 8;
  localparam int QA_W    = 7;
  localparam int QB_W    = 6;
  localparam int Q4_W    = 4;
  localparam int BF_BIAS = 127;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_DUAL   = 2'b01,
    MODE_QUAD   = 2'b10,
    MODE_FLOAT  = 2'b11
  } mad_mode_t;

  // Control word, low bits of the control register
  typedef struct packed {
    logic [3:0] shift;
    logic       accum;
    logic       sub;
    logic       bypass;
    logic       sgn;
    mad_mode_t  mode;
  } mad_cfg_t;

  localparam mad_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic [47:0] c;
    logic [17:0] b;
    logic [18:0] a;
  } mad_opnd_t;

endpackage

// ===== src/mad_block.sv
`timescale 1ns/1ps

// Functional notes
// RULE1 - Normal: 19x18 product, 48-bit add/sub
// RULE2 - Dual: 11x10 and 8x8, two 24-bit lanes
// RULE3 - Quad: 7x6 plus three 4x4, 12-bit lanes
// RULE4 - Quad 7x6 lane result truncated to 12 bits
// RULE5 - Float: fused bfloat16 multiply then add
// RULE6 - 4-bit right shift on every active lane; the float mode result is not shifted
// RULE7 - Signed or unsigned operands per config
// RULE8 - One signedness setting shared by all lanes
// RULE9 - Fabric drives factors on A and B
// RULE10 - Product may bypass adder or feed it
// RULE11 - Result registered when enabled, sync clear
// RULE12 - Accumulate adds to previous registered result
module mad_block (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ce,
  input  wire logic                 srst,
  input  wire mad_pkg::mad_opnd_t   opnd,
  output logic      [47:0]          result
);

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [47:0] ext(logic [18:0] x, int w, logic s);
    logic [47:0] m;
    m = (48'h1 << w) - 48'h1;
    if (s && x[w-1]) begin
      return 48'(x) | ~m;
    end
    return 48'(x) & m;
  endfunction

  // Shift, then bypass or add/sub, then cut to lane width
  function automatic logic [47:0] lane(logic [47:0] p, logic [47:0] o,
                                       mad_pkg::mad_cfg_t cf, int w);
    logic [47:0] s;
    logic [47:0] r;
    s = cf.sgn ? 48'($signed(p) >>> cf.shift) : p >> cf.shift;  // [RULE6] [RULE7]
    if (cf.bypass) begin
      r = s;  // [RULE10]
    end else if (cf.sub) begin
      r = o - s;
    end else begin
      r = o + s;
    end
    return r & ((48'h1 << w) - 48'h1);
  endfunction

  // Truncating bfloat16 fused multiply-add, subnormals flushed to zero
  function automatic logic [15:0] bf_fma(logic [15:0] x, logic [15:0] y,
                                         logic [15:0] z, logic neg);
    logic        sp;
    logic        so;
    logic [15:0] mp;
    logic [39:0] ap;
    logic [39:0] az;
    logic [39:0] sm;
    int          ep;
    int          ez;
    int          eo;
    int          d;
    int          msb;
    int          e;
    sp = x[15] ^ y[15] ^ neg;
    mp = 16'({1'b1, x[6:0]}) * 16'({1'b1, y[6:0]});
    if (x[14:7] == 8'h00 || y[14:7] == 8'h00) begin
      mp = 16'h0;
    end
    ep = int'(x[14:7]) + int'(y[14:7]) - mad_pkg::BF_BIAS;
    ez = int'(z[14:7]);
    az = (ez == 0) ? 40'h0 : {9'h0, 1'b1, z[6:0], 23'h0};
    ap = {8'h0, mp, 16'h0};
    // Zero terms take the other exponent so alignment never discards data
    if (mp == 16'h0) begin
      ep = ez;
    end
    if (az == 40'h0) begin
      ez = ep;
    end
    d = ep - ez;
    if (d >= 0) begin
      eo = ep;
      az = (d > 39) ? 40'h0 : az >> d;
    end else begin
      eo = ez;
      ap = (d < -39) ? 40'h0 : ap >> (-d);
    end
    if (sp == z[15]) begin
      sm = ap + az;
      so = sp;
    end else if (ap >= az) begin
      sm = ap - az;
      so = sp;
    end else begin
      sm = az - ap;
      so = z[15];
    end
    msb = 0;
    for (int i = 0; i < 40; i++) begin
      if (sm[i]) begin
        msb = i;
      end
    end
    e = eo + msb - 30;
    sm = sm << (39 - msb);
    if (sm == 40'h0 || e <= 0) begin
      return {so, 15'h0};
    end
    if (e >= 255) begin
      return {so, 8'hff, 7'h0};
    end
    return {so, 8'(e), sm[38:32]};
  endfunction

  // ************************************************
  // Register bus
  // ************************************************
  mad_pkg::mad_cfg_t cfg_r;
  mad_pkg::mad_cfg_t cfg_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic              pready_r;
  logic              pready_nxt;
  logic              pslverr_r;
  logic              pslverr_nxt;
  logic [47:0]       res_r;
  logic [47:0]       res_nxt;

  // Read data is captured in setup; answer lands one cycle later
  always_comb begin
    cfg_nxt     = cfg_r;
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = 1'b0;
      prdata_nxt  = 32'h0;
      if (paddr == mad_pkg::REG_CTRL) begin
        prdata_nxt = 32'(cfg_r);
      end else if (paddr == mad_pkg::REG_RES_LO) begin
        prdata_nxt = res_r[31:0];
      end else if (paddr == mad_pkg::REG_RES_HI) begin
        prdata_nxt = 32'(res_r[47:32]);
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (psel && penable && pready_r && pwrite && paddr == mad_pkg::REG_CTRL) begin
      cfg_nxt = mad_pkg::mad_cfg_t'(pwdata[$bits(mad_pkg::mad_cfg_t)-1:0]);  // [RULE8]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r     <= mad_pkg::CFG_RST;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ************************************************
  // Multiply-add datapath
  // ************************************************
  logic [47:0] o;
  logic [47:0] t;
  logic [47:0] lv;
  logic [47:0] pa;
  logic [47:0] pb;
  logic [15:0] fz;
  logic        s;

  always_comb begin
    s  = cfg_r.sgn;  // [RULE8]
    o  = cfg_r.accum ? res_r : opnd.c;  // [RULE12]
    t  = 48'h0;
    lv = 48'h0;
    pa = 48'h0;
    pb = 48'h0;
    fz = 16'h0;
    case (cfg_r.mode)
      mad_pkg::MODE_NORMAL: begin
        pa = ext(opnd.a, mad_pkg::A_W, s);  // [RULE9]
        pb = ext(19'(opnd.b), mad_pkg::B_W, s);
        t  = lane(pa * pb, o, cfg_r, mad_pkg::ACC_W);  // [RULE1]
      end
      mad_pkg::MODE_DUAL: begin
        pa = ext(19'(opnd.a[10:0]), mad_pkg::DA_W, s);
        pb = ext(19'(opnd.b[9:0]), mad_pkg::DB_W, s);
        lv = lane(pa * pb, 48'(o[23:0]), cfg_r, mad_pkg::DUAL_W);  // [RULE2]
        t[23:0] = lv[23:0];
        pa = ext(19'(opnd.a[18:11]), mad_pkg::D8_W, s);
        pb = ext(19'(opnd.b[17:10]), mad_pkg::D8_W, s);
        lv = lane(pa * pb, 48'(o[47:24]), cfg_r, mad_pkg::DUAL_W);  // [RULE2]
        t[47:24] = lv[23:0];
      end
      mad_pkg::MODE_QUAD: begin
        for (int k = 0; k < 4; k++) begin
          if (k == 0) begin
            pa = ext(19'(opnd.a[6:0]), mad_pkg::QA_W, s);
            pb = ext(19'(opnd.b[5:0]), mad_pkg::QB_W, s);
          end else begin
            pa = ext(19'(opnd.a[4*k+3 +: 4]), mad_pkg::Q4_W, s);
            pb = ext(19'(opnd.b[4*k+2 +: 4]), mad_pkg::Q4_W, s);
          end
          // The 13-bit 7x6 product is cut to the lane here
          lv = lane(pa * pb, 48'(o[12*k +: 12]), cfg_r, mad_pkg::QUAD_W);  // [RULE3] [RULE4]
          t[12*k +: 12] = lv[11:0];
        end
      end
      default: begin
        fz = cfg_r.bypass ? 16'h0 : o[15:0];  // [RULE10]
        t  = {32'h0, bf_fma(opnd.a[15:0], opnd.b[15:0], fz, cfg_r.sub)};  // [RULE5]
      end
    endcase
    res_nxt = res_r;
    if (srst) begin
      res_nxt = 48'h0;  // [RULE11]
    end else if (ce) begin
      res_nxt = t;  // [RULE11]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_r <= 48'h0;
    end else begin
      res_r <= res_nxt;
    end
  end

  assign result = res_r;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic go;
  logic plain;
  assign go    = ce && !srst;
  assign plain = go && !cfg_r.sgn && cfg_r.shift == 4'h0 && !cfg_r.accum;

  property p_norm;
    plain && cfg_r.mode == mad_pkg::MODE_NORMAL && !cfg_r.bypass && !cfg_r.sub
    |=> res_r == $past(opnd.c) + 48'($past(opnd.a)) * 48'($past(opnd.b));
  endproperty
  a_norm: assert property (p_norm) else $error("normal add wrong");  // [RULE1]
  property p_dual;
    plain && cfg_r.mode == mad_pkg::MODE_DUAL && !cfg_r.bypass && cfg_r.sub
    |=> res_r[47:24] == $past(opnd.c[47:24]) - 24'($past(opnd.a[18:11])) * 24'($past(opnd.b[17:10]))
     && res_r[23:0] == $past(opnd.c[23:0]) - 24'($past(opnd.a[10:0])) * 24'($past(opnd.b[9:0]));
  endproperty
  a_dual: assert property (p_dual) else $error("dual lanes wrong");  // [RULE2]
  property p_quad;
    plain && cfg_r.mode == mad_pkg::MODE_QUAD && !cfg_r.bypass && !cfg_r.sub
    |=> res_r[23:12] == $past(opnd.c[23:12]) + 12'($past(opnd.a[10:7])) * 12'($past(opnd.b[9:6]))
     && res_r[47:36] == $past(opnd.c[47:36]) + 12'($past(opnd.a[18:15])) * 12'($past(opnd.b[17:14]));
  endproperty
  a_quad: assert property (p_quad) else $error("quad lanes wrong");  // [RULE3]
  property p_trunc;
    plain && cfg_r.mode == mad_pkg::MODE_QUAD && cfg_r.bypass
    |=> res_r[11:0] == 12'(13'($past(opnd.a[6:0])) * 13'($past(opnd.b[5:0])));
  endproperty
  a_trunc: assert property (p_trunc) else $error("7x6 lane not cut");  // [RULE4]
  property p_fp;
    go && cfg_r.mode == mad_pkg::MODE_FLOAT && !cfg_r.accum && !cfg_r.bypass
    && opnd.a[14:0] == 15'h0 && opnd.c[14:7] != 8'h00 && opnd.c[14:7] != 8'hff
    |=> res_r == 48'($past(opnd.c[15:0]));
  endproperty
  a_fp: assert property (p_fp) else $error("float zero product");  // [RULE5]
  property p_shift;
    go && !cfg_r.sgn && !cfg_r.accum && cfg_r.mode == mad_pkg::MODE_NORMAL && cfg_r.bypass
    |=> res_r == (48'($past(opnd.a)) * 48'($past(opnd.b))) >> $past(cfg_r.shift);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");  // [RULE6]
  property p_sign;
    go && cfg_r.sgn && cfg_r.shift == 4'h0 && cfg_r.bypass && cfg_r.mode == mad_pkg::MODE_NORMAL
    |=> res_r == {{29{$past(opnd.a[18])}}, $past(opnd.a)} * {{30{$past(opnd.b[17])}}, $past(opnd.b)};
  endproperty
  a_sign: assert property (p_sign) else $error("signed product wrong");  // [RULE7]
  property p_onesign;
    go && cfg_r.sgn && cfg_r.shift == 4'h0 && cfg_r.bypass && cfg_r.mode == mad_pkg::MODE_DUAL
    |=> res_r[47:24] == {{16{$past(opnd.a[18])}}, $past(opnd.a[18:11])}
                        * {{16{$past(opnd.b[17])}}, $past(opnd.b[17:10])};
  endproperty
  a_onesign: assert property (p_onesign) else $error("dual sign wrong");  // [RULE8]
  property p_sub;
    plain && cfg_r.mode == mad_pkg::MODE_NORMAL && !cfg_r.bypass && cfg_r.sub
    |=> res_r == $past(opnd.c) - 48'($past(opnd.a)) * 48'($past(opnd.b));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong");  // [RULE10]
  property p_hold;
    !ce && !srst ##1 !ce && !srst |=> $stable(res_r) && res_r == $past(res_r, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");  // [RULE11]
  property p_clr;
    srst |=> res_r == 48'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");  // [RULE11]
  property p_acc;
    go && cfg_r.accum && !cfg_r.sgn && cfg_r.shift == 4'h0 && !cfg_r.bypass && !cfg_r.sub
    && cfg_r.mode == mad_pkg::MODE_NORMAL
    |=> res_r == $past(res_r) + 48'($past(opnd.a)) * 48'($past(opnd.b));
  endproperty
  a_acc: assert property (p_acc) else $error("accumulate wrong");  // [RULE12]
  c_dual: cover property (go && cfg_r.mode == mad_pkg::MODE_DUAL);
  c_quad: cover property (go && cfg_r.mode == mad_pkg::MODE_QUAD);
  c_fma:  cover property (go && cfg_r.mode == mad_pkg::MODE_FLOAT);
  c_acc:  cover property (go && cfg_r.accum ##1 go && cfg_r.accum);

endmodule

// ===== verif/mad_fabric.sv
`timescale 1ns/1ps

// ****************************************
// Fabric side: presents operands for one enabled cycle per request
// ****************************************
module mad_fabric (
  input  wire logic               sys_clk,
  input  wire logic               req,
  input  wire mad_pkg::mad_opnd_t val,
  output logic                    ce,
  output mad_pkg::mad_opnd_t      opnd
);
  initial begin
    ce = 1'b0;
    opnd = '0;
  end
  // Factors on a and b, addend on c; idle operands toggle so a held result is proven
  always @(posedge sys_clk) begin
    ce <= req;
    opnd <= req ? val : ~opnd;
  end
endmodule

// ===== verif/test_fpga_dsp_multiply_add_block.sv
`timescale 1ns/1ps

module test_fpga_dsp_multiply_add_block;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               ce;
  logic               srst = 1'b0;
  logic               req = 1'b0;
  mad_pkg::mad_opnd_t val = '0;
  mad_pkg::mad_opnd_t opnd;
  logic [47:0]        result;
  logic [47:0]        r;
  logic [31:0]        rd;
  logic               er;
  int                 err_count = 0;
  int                 tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  mad_block dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce(ce), .srst(srst), .opnd(opnd), .result(result)
  );

  mad_fabric u_fab (.sys_clk(sys_clk), .req(req), .val(val), .ce(ce), .opnd(opnd));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entered just after a rising edge; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge sys_clk);
  endtask

  task automatic run(input logic [9:0] cw, input logic [18:0] a, input logic [17:0] b, input logic [47:0] c);
    apb(1'b1, mad_pkg::REG_CTRL, {22'h0, cw});
    val <= '{c: c, b: b, a: a};
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    r = result;
    @(posedge sys_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    chk("result reset", result, 48'h0);
    apb(1'b0, mad_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 48'(rd), 48'h0);
    apb(1'b1, mad_pkg::REG_CTRL, 32'hffffffff);
    apb(1'b0, mad_pkg::REG_CTRL, 32'h0);
    chk("ctrl bits", 48'(rd), 48'h3ff);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", 48'(er), 48'h1);
  endtask

  task automatic t_norm();
    run(10'h000, 19'h7ffff, 18'h3ffff, 48'h1);
    chk("normal", r, 48'(19'h7ffff) * 48'(18'h3ffff) + 48'h1);
    apb(1'b0, mad_pkg::REG_RES_HI, 32'h0);
    chk("res hi", 48'(rd), 48'h0000_0000_001f);
    apb(1'b0, mad_pkg::REG_RES_LO, 32'h0);
    chk("res lo", 48'(rd), 48'h0000_fff4_0002);
    apb(1'b1, mad_pkg::REG_RES_LO, 32'h0);
    chk("res lo write no err", 48'(er), 48'h0);
    apb(1'b0, mad_pkg::REG_RES_LO, 32'h0);
    chk("res lo write ignored", 48'(rd), 48'h0000_fff4_0002);
    run(10'h014, 19'h7fffd, 18'h5, 48'h64);
    chk("signed sub", r, 48'h73);
    run(10'h104, 19'h7fff0, 18'h1, 48'h0);
    chk("arith shift", r, 48'hffffffffffff);
    run(10'h010, 19'h3, 18'h5, 48'h64);
    chk("unsigned sub", r, 48'h55);
    run(10'h00c, 19'h7fffd, 18'h5, 48'h5555);
    chk("signed bypass", r, 48'hfffffffffff1);
    run(10'h008, 19'h100, 18'h10, 48'h5555);
    chk("bypass", r, 48'h1000);
    run(10'h020, 19'h2, 18'h3, 48'h5555);
    chk("accumulate", r, 48'h1006);
  endtask

  task automatic t_dual();
    run(10'h041, 19'h7ffff, 18'h3ffff, {24'h10, 24'hffffff});
    chk("dual", r, {(24'(8'hff) * 24'(8'hff) >> 1) + 24'h10,
                    (24'(11'h7ff) * 24'(10'h3ff) >> 1) + 24'hffffff});
    run(10'h011, 19'h7ffff, 18'h3ffff, {24'h010000, 24'h200000});
    chk("dual sub", r, {24'h0001ff, 24'h000bff});
    run(10'h00d, 19'h7ffff, 18'h3ffff, 48'h0);
    chk("dual signed", r, {24'h1, 24'h1});
  endtask

  task automatic t_quad();
    run(10'h002, 19'h7ffff, 18'h3ffff, 48'h0);
    chk("quad", r, {12'he1, 12'he1, 12'he1, 12'(14'(7'h7f) * 14'(6'h3f))});
    run(10'h006, 19'h7ffff, 18'h3ffff, 48'h0);
    chk("quad signed", r, {12'h1, 12'h1, 12'h1, 12'h1});
    run(10'h00a, 19'h11a7f, 18'h159ff, 48'h0);
    chk("quad lanes", r, {12'h00a, 12'h012, 12'h01c, 12'hf41});
  endtask

  task automatic t_float();
    run(10'h003, 19'h3fc0, 18'h4000, 48'h3f80);
    chk("fma add", r, 48'h4080);
    run(10'h013, 19'h3fc0, 18'h4000, 48'h3f80);
    chk("fma sub", r, 48'hc000);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("ce low holds", result, 48'hc000);
    @(posedge sys_clk);
    val <= '{c: 48'h3f80, b: 18'h4000, a: 19'h3fc0};
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("clear beats ce", result, 48'h0);
    @(posedge sys_clk);
    run(10'h003, 19'h0, 18'h4000, 48'h3f80);
    chk("fma zero product", r, 48'h3f80);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("sync clear", result, 48'h0);
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_norm();
    t_dual();
    t_quad();
    t_float();
    test_done();
  end
endmodule
